// ---- dv/mbr_host.sv ----
// Host side serial master model that drives the register bank pins.
`timescale 1ns/1ps
`default_nettype none
module mbr_host #(
  parameter int HALF = 10
) (
  // Clock.
  input wire logic clk_i,
  // Serial pins.
  output logic sck_o,
  output logic nss_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial begin
    sck_o = 1'b0;
    nss_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // One frame of command byte and one data byte, MSB first, sampled on rising edges.
  // Half periods are well above the minimum so the synchroniser lag never eats a bit.
  task automatic xfer(input logic wr, input mbr_pkg::mbr_addr_t addr,
      input mbr_pkg::mbr_byte_t wdata, output mbr_pkg::mbr_byte_t rdata);
    logic [15:0] sh;
    sh = {wr, addr, wdata};
    rdata = 8'h00;
    @(posedge clk_i);
    nss_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 15; i >= 0; i--) begin
      mosi_o <= sh[i];
      repeat (HALF) @(posedge clk_i);
      sck_o <= 1'b1;
      rdata = {rdata[6:0], miso_i};
      repeat (HALF) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (HALF) @(posedge clk_i);
    nss_n_o <= 1'b1;
    // An idle data line holds no meaning, so it is left flipped rather than stable.
    mosi_o <= ~sh[0];
    repeat (6) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ---- dv/tb_modem_buffer_irq_status_regs.sv ----
// Self-checking bench for the modem buffer register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_modem_buffer_irq_status_regs;
  typedef struct packed {
    logic wr;
    mbr_pkg::mbr_addr_t addr;
    mbr_pkg::mbr_byte_t data;
    mbr_pkg::mbr_byte_t exp;
  } mbr_row_s;

  logic clk_i;
  logic rst_i;
  logic sck, nss_n, mosi, miso, miso_oe;
  wire miso_w;
  logic [7:0] evt;
  logic pkt_ok, sleep, rx_entry, pkt_info;
  logic [7:0] last_start, rx_len, snr;
  logic [2:0] code_rate;
  logic [4:0] modem_flags;
  logic [7:0] mdm_addr, mdm_wdata, mdm_rdata;
  logic mdm_we;
  logic [7:0] tx_base, rx_base, irq;
  mbr_pkg::mbr_byte_t rd;
  int bad_count = 0;
  int compares = 0;

  // Reads follow every row; writes to read-only or unmapped places must not stick.
  mbr_row_s rows [14] = '{
    '{1'b0, 7'h0e, 8'h00, 8'h80}, '{1'b0, 7'h0f, 8'h00, 8'h00},
    '{1'b0, 7'h11, 8'h00, 8'h00}, '{1'b0, 7'h12, 8'h00, 8'h00},
    '{1'b1, 7'h0e, 8'h55, 8'h55}, '{1'b1, 7'h0f, 8'ha3, 8'ha3},
    '{1'b1, 7'h11, 8'h0f, 8'h0f}, '{1'b1, 7'h10, 8'h77, 8'h3c},
    '{1'b1, 7'h13, 8'h77, 8'h21}, '{1'b1, 7'h19, 8'h00, 8'hf6},
    '{1'b1, 7'h18, 8'h00, 8'hab}, '{1'b1, 7'h30, 8'h5a, 8'h00},
    '{1'b1, 7'h0d, 8'h20, 8'h20}, '{1'b1, 7'h00, 8'hc3, 8'h9e}};

  assign miso_w = miso_oe ? miso : 1'bz;

  mbr_regs #(.BUF_DEPTH(256)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .spi_sck_i(sck), .spi_nss_n_i(nss_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
    .evt_i(evt), .pkt_ok_i(pkt_ok), .sleep_i(sleep), .rx_entry_i(rx_entry),
    .pkt_info_i(pkt_info), .last_start_i(last_start), .rx_len_i(rx_len), .snr_i(snr),
    .code_rate_i(code_rate), .modem_flags_i(modem_flags), .mdm_addr_i(mdm_addr),
    .mdm_we_i(mdm_we), .mdm_wdata_i(mdm_wdata), .mdm_rdata_o(mdm_rdata),
    .tx_base_o(tx_base), .rx_base_o(rx_base), .irq_o(irq)
  );

  mbr_host i_host (
    .clk_i(clk_i), .sck_o(sck), .nss_n_o(nss_n), .mosi_o(mosi), .miso_i(miso_w)
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic check(input string name, input mbr_pkg::mbr_byte_t seen,
      input mbr_pkg::mbr_byte_t exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd_reg(input mbr_pkg::mbr_addr_t a, input mbr_pkg::mbr_byte_t exp);
    i_host.xfer(1'b0, a, 8'h00, rd);
    check($sformatf("reg %h", a), rd, exp);
  endtask

  task automatic pulse_evt(input logic [7:0] v);
    evt <= v;
    @(posedge clk_i);
    evt <= 8'h00;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_i);
    bad_count++;
    $display("ERROR watchdog expired before the sequence ended");
    complete_run();
  end

  initial begin
    rst_i = 1'b1;
    {evt, pkt_ok, sleep, rx_entry, pkt_info} = '0;
    {last_start, rx_len, snr, code_rate, modem_flags} = '0;
    {mdm_addr, mdm_we, mdm_wdata} = '0;
    repeat (2) @(posedge clk_i);
    check("tx base in reset", tx_base, 8'h80);
    check("rx base in reset", rx_base, 8'h00);
    check("irq in reset", irq, 8'h00);
    rst_i <= 1'b0;
    {last_start, rx_len, snr, pkt_info} <= {8'h3c, 8'h21, 8'hf6, 1'b1};
    {code_rate, modem_flags} <= {3'h5, 5'h0b};
    {mdm_addr, mdm_we, mdm_wdata} <= {8'h21, 1'b1, 8'h9e};
    @(posedge clk_i);
    // Inputs move after capture so a register that follows them live shows up wrong.
    {last_start, rx_len, snr, pkt_info, mdm_we} <= '0;
    repeat (4) @(posedge clk_i);
    foreach (rows[k]) begin
      if (rows[k].wr) i_host.xfer(1'b1, rows[k].addr, rows[k].data, rd);
      rd_reg(rows[k].addr, rows[k].exp);
    end
    check("tx base pin", tx_base, 8'h55);
    check("rx base pin", rx_base, 8'ha3);
    mdm_addr <= 8'h20;
    repeat (2) @(posedge clk_i);
    check("buffer via modem", mdm_rdata, 8'hc3);
    pulse_evt(8'hff);
    check("irq masked", irq, 8'hf0);
    rd_reg(7'h12, 8'hff);
    i_host.xfer(1'b1, 7'h12, 8'ha5, rd);
    rd_reg(7'h12, 8'h5a);
    check("irq after clear", irq, 8'h50);
    i_host.xfer(1'b1, 7'h12, 8'hff, rd);
    i_host.xfer(1'b1, 7'h11, 8'h00, rd);
    pulse_evt(8'h01);
    rd_reg(7'h12, 8'h01);
    check("irq activity", irq, 8'h01);
    // Entry into receive must drop the header counted by the all-ones event pulse above.
    rx_entry <= 1'b1;
    @(posedge clk_i);
    rx_entry <= 1'b0;
    for (int n = 0; n < 259; n++) begin
      evt <= 8'h10;
      pkt_ok <= (n < 2);
      @(posedge clk_i);
      evt <= 8'h00;
      pkt_ok <= 1'b0;
      @(posedge clk_i);
    end
    rd_reg(7'h12, 8'h11);
    check("irq header", irq, 8'h11);
    rd_reg(7'h14, 8'h01);
    rd_reg(7'h15, 8'h03);
    rd_reg(7'h16, 8'h00);
    rd_reg(7'h17, 8'h02);
    i_host.xfer(1'b1, 7'h15, 8'hff, rd);
    rd_reg(7'h15, 8'h03);
    sleep <= 1'b1;
    @(posedge clk_i);
    sleep <= 1'b0;
    rd_reg(7'h15, 8'h00);
    rd_reg(7'h17, 8'h00);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check("tx base reset again", tx_base, 8'h80);
    check("rx base reset again", rx_base, 8'h00);
    check("irq reset again", irq, 8'h00);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd_reg(7'h12, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire

// ---- logic/mbr_acc_if.sv ----
// Register access carrier between the serial front end and the register bank.
`timescale 1ns/1ps
`default_nettype none
interface mbr_acc_if;
  mbr_pkg::mbr_addr_t addr;
  logic wr;
  logic rd;
  mbr_pkg::mbr_byte_t wdata;
  mbr_pkg::mbr_byte_t rdata;
  modport spi (output addr, output wr, output rd, output wdata, input rdata);
  modport bank (input addr, input wr, input rd, input wdata, output rdata);
endinterface
`default_nettype wire

// ---- logic/mbr_cfg.svh ----
// Register offsets, reset values and field positions of the modem buffer register bank.
`ifndef MBR_CFG_SVH
`define MBR_CFG_SVH

`define MBR_ADR_BUF_DATA 7'h00
`define MBR_ADR_BUF_PTR 7'h0d
`define MBR_ADR_TX_BASE 7'h0e
`define MBR_ADR_RX_BASE 7'h0f
`define MBR_ADR_LAST_START 7'h10
`define MBR_ADR_IRQ_MASK 7'h11
`define MBR_ADR_IRQ_FLAGS 7'h12
`define MBR_ADR_RX_LEN 7'h13
`define MBR_ADR_HDR_CNT_HI 7'h14
`define MBR_ADR_HDR_CNT_LO 7'h15
`define MBR_ADR_PKT_CNT_HI 7'h16
`define MBR_ADR_PKT_CNT_LO 7'h17
`define MBR_ADR_MODEM_STATE 7'h18
`define MBR_ADR_PKT_SNR 7'h19

`define MBR_RST_BUF_PTR 8'h00
`define MBR_RST_TX_BASE 8'h80
`define MBR_RST_RX_BASE 8'h00
`define MBR_RST_IRQ_MASK 8'h00
`define MBR_RST_IRQ_FLAGS 8'h00
`define MBR_RST_MODEM_STATE 8'h10

`define MBR_IRQ_RX_TIMEOUT 7
`define MBR_IRQ_RX_COMPLETE 6
`define MBR_IRQ_CRC_ERROR 5
`define MBR_IRQ_HEADER_OK 4
`define MBR_IRQ_TX_COMPLETE 3
`define MBR_IRQ_SCAN_END 2
`define MBR_IRQ_HOP_CHANGE 1
`define MBR_IRQ_ACT_FOUND 0

`define MBR_SPI_WRITE_BIT 7
`define MBR_SPI_LAST_BIT 3'h7

`endif

// ---- logic/mbr_pkg.sv ----
// Types shared by the modem buffer register bank modules.
package mbr_pkg;
  typedef enum logic [1:0] {
    SPI_IDLE,
    SPI_ADDR,
    SPI_DATA
  } mbr_spi_e;
  typedef logic [7:0] mbr_byte_t;
  typedef logic [6:0] mbr_addr_t;
endpackage

// ---- logic/mbr_pkt_buf.sv ----
// Packet data buffer with a host port and a modem port.
`timescale 1ns/1ps
`default_nettype none
module mbr_pkt_buf #(
  parameter int DW = 8,
  parameter int AW = 8,
  parameter int DEPTH = 256
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Host port, read is combinational.
  input wire logic [AW-1:0] h_addr_i,
  input wire logic h_we_i,
  input wire logic [DW-1:0] h_wdata_i,
  output logic [DW-1:0] h_rdata_o,
  // Modem port, read data registered.
  input wire logic [AW-1:0] m_addr_i,
  input wire logic m_we_i,
  input wire logic [DW-1:0] m_wdata_i,
  output logic [DW-1:0] m_rdata_o
);
  logic [DW-1:0] mem [DEPTH];

  // Host write comes last so it wins a same-address collision.
  always_ff @(posedge clk_i) begin
    if (m_we_i) begin
      mem[m_addr_i] <= m_wdata_i;
    end
    if (h_we_i) begin
      mem[h_addr_i] <= h_wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      m_rdata_o <= '0;
    end else begin
      m_rdata_o <= mem[m_addr_i];
    end
  end

  assign h_rdata_o = mem[h_addr_i];
endmodule
`default_nettype wire

// ---- logic/mbr_regs.sv ----
// Modem buffer pointers, interrupt flags, receive counters and status registers.
//
// Overview of operation
// RULE1: Writable transmit base pointer, resets to 0x80.
// RULE2: Writable receive base pointer, resets to 0x00.
// RULE3: Read-only start address of last packet.
// RULE4: Mask bit set suppresses matching interrupt line.
// RULE5: Flag bits ordered timeout down to activity.
// RULE6: Writing one clears exactly that flag.
// RULE7: Activity found during scan sets bit zero.
// RULE8: Read-only payload byte count of last packet.
// RULE9: Sixteen-bit valid header count, high byte first.
// RULE10: Sixteen-bit valid packet count, high byte first.
// RULE11: Sleep clears both header and packet counters.
// RULE12: Status: code rate high, five modem flags low.
// RULE13: Read-only SNR, two's complement, times four.
// RULE14: Writable buffer pointer selects serial data location.
// RULE15: Zero writes keep flags; read-only values ignore writes.
`include "mbr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mbr_regs #(
  parameter int BUF_DEPTH = 256
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial register port.
  input wire logic spi_sck_i,
  input wire logic spi_nss_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  // Modem events, one-cycle pulses in flag bit order.
  input wire logic [7:0] evt_i,
  input wire logic pkt_ok_i,
  input wire logic sleep_i,
  input wire logic rx_entry_i,
  // Modem packet results, taken on pkt_info_i.
  input wire logic pkt_info_i,
  input wire logic [7:0] last_start_i,
  input wire logic [7:0] rx_len_i,
  input wire logic [7:0] snr_i,
  // Modem live status.
  input wire logic [2:0] code_rate_i,
  input wire logic [4:0] modem_flags_i,
  // Modem buffer port.
  input wire logic [7:0] mdm_addr_i,
  input wire logic mdm_we_i,
  input wire logic [7:0] mdm_wdata_i,
  output logic [7:0] mdm_rdata_o,
  // Control and interrupt lines.
  output logic [7:0] tx_base_o,
  output logic [7:0] rx_base_o,
  output logic [7:0] irq_o
);
  mbr_acc_if acc ();

  logic [7:0] buf_ptr_r;
  logic [7:0] tx_base_r;
  logic [7:0] rx_base_r;
  logic [7:0] mask_r;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] last_start_r;
  logic [7:0] rx_len_r;
  logic [7:0] snr_r;
  logic [15:0] hdr_cnt_r;
  logic [15:0] pkt_cnt_r;
  logic [7:0] stat_r;
  logic [7:0] rdata_r;
  logic [7:0] rd_mux;
  logic [7:0] buf_rdata;
  logic cnt_clr;

  function automatic logic wr_hit(input logic wr, input logic [6:0] addr,
      input logic [6:0] reg_a);
    wr_hit = wr && (addr == reg_a);
  endfunction

  mbr_spi_slave u_spi (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sck_i(spi_sck_i),
    .nss_n_i(spi_nss_n_i),
    .mosi_i(spi_mosi_i),
    .miso_o(spi_miso_o),
    .miso_oe_o(spi_miso_oe_o),
    .acc(acc.spi)
  );

  mbr_pkt_buf #(
    .DW(8),
    .AW(8),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .h_addr_i(buf_ptr_r),
    .h_we_i(wr_hit(acc.wr, acc.addr, `MBR_ADR_BUF_DATA)),
    .h_wdata_i(acc.wdata),
    .h_rdata_o(buf_rdata),
    .m_addr_i(mdm_addr_i),
    .m_we_i(mdm_we_i),
    .m_wdata_i(mdm_wdata_i),
    .m_rdata_o(mdm_rdata_o)
  );

  // Each data access walks the pointer, so a burst streams through the buffer.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_ptr_r <= `MBR_RST_BUF_PTR;
    end else if (wr_hit(acc.wr | acc.rd, acc.addr, `MBR_ADR_BUF_DATA)) begin
      buf_ptr_r <= buf_ptr_r + 8'h01; // see RULE14
    end else if (wr_hit(acc.wr, acc.addr, `MBR_ADR_BUF_PTR)) begin
      buf_ptr_r <= acc.wdata; // see RULE14
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_base_r <= `MBR_RST_TX_BASE;
      rx_base_r <= `MBR_RST_RX_BASE;
      mask_r <= `MBR_RST_IRQ_MASK;
    end else begin
      if (wr_hit(acc.wr, acc.addr, `MBR_ADR_TX_BASE)) begin
        tx_base_r <= acc.wdata; // see RULE1
      end
      if (wr_hit(acc.wr, acc.addr, `MBR_ADR_RX_BASE)) begin
        rx_base_r <= acc.wdata; // see RULE2
      end
      if (wr_hit(acc.wr, acc.addr, `MBR_ADR_IRQ_MASK)) begin
        mask_r <= acc.wdata;
      end
    end
  end

  // A new event in the clearing cycle survives: set beats clear.
  always_comb begin
    flags_nxt = flags_r;
    if (wr_hit(acc.wr, acc.addr, `MBR_ADR_IRQ_FLAGS)) begin
      flags_nxt = flags_r & ~acc.wdata; // see RULE6 see RULE15
    end
    flags_nxt = flags_nxt | evt_i; // see RULE5 see RULE7
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_r <= `MBR_RST_IRQ_FLAGS;
      irq_o <= 8'h00;
    end else begin
      flags_r <= flags_nxt;
      irq_o <= flags_r & ~mask_r; // see RULE4
    end
  end

  // Packet results are held until the modem reports the next packet.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_start_r <= 8'h00;
      rx_len_r <= 8'h00;
      snr_r <= 8'h00;
    end else if (pkt_info_i) begin
      last_start_r <= last_start_i; // see RULE3
      rx_len_r <= rx_len_i; // see RULE8
      snr_r <= snr_i; // see RULE13
    end
  end

  assign cnt_clr = sleep_i | rx_entry_i;

  // Counters wrap at 16 bits; clearing takes priority over counting.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hdr_cnt_r <= 16'h0000;
      pkt_cnt_r <= 16'h0000;
    end else if (cnt_clr) begin
      hdr_cnt_r <= 16'h0000; // see RULE11
      pkt_cnt_r <= 16'h0000; // see RULE11
    end else begin
      if (evt_i[`MBR_IRQ_HEADER_OK]) begin
        hdr_cnt_r <= hdr_cnt_r + 16'h0001; // see RULE9
      end
      if (pkt_ok_i) begin
        pkt_cnt_r <= pkt_cnt_r + 16'h0001; // see RULE10
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_r <= `MBR_RST_MODEM_STATE;
    end else begin
      stat_r <= {code_rate_i, modem_flags_i}; // see RULE12
    end
  end

  // Unmapped addresses read as zero; read-only ones have no write path.
  always_comb begin
    case (acc.addr)
      `MBR_ADR_BUF_DATA: rd_mux = buf_rdata;
      `MBR_ADR_BUF_PTR: rd_mux = buf_ptr_r;
      `MBR_ADR_TX_BASE: rd_mux = tx_base_r;
      `MBR_ADR_RX_BASE: rd_mux = rx_base_r;
      `MBR_ADR_LAST_START: rd_mux = last_start_r;
      `MBR_ADR_IRQ_MASK: rd_mux = mask_r;
      `MBR_ADR_IRQ_FLAGS: rd_mux = flags_r;
      `MBR_ADR_RX_LEN: rd_mux = rx_len_r;
      `MBR_ADR_HDR_CNT_HI: rd_mux = hdr_cnt_r[15:8];
      `MBR_ADR_HDR_CNT_LO: rd_mux = hdr_cnt_r[7:0];
      `MBR_ADR_PKT_CNT_HI: rd_mux = pkt_cnt_r[15:8];
      `MBR_ADR_PKT_CNT_LO: rd_mux = pkt_cnt_r[7:0];
      `MBR_ADR_MODEM_STATE: rd_mux = stat_r;
      `MBR_ADR_PKT_SNR: rd_mux = snr_r;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
    end else if (acc.rd) begin
      rdata_r <= rd_mux;
    end
  end

  assign acc.rdata = rdata_r;
  assign tx_base_o = tx_base_r;
  assign rx_base_o = rx_base_r;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_TX_BASE: assert property (wr_hit(acc.wr, acc.addr, `MBR_ADR_TX_BASE) |=> // see RULE1
    tx_base_o == $past(acc.wdata)) else $error("tx base not written");
  AST_RX_BASE: assert property (wr_hit(acc.wr, acc.addr, `MBR_ADR_RX_BASE) |=> // see RULE2
    rx_base_o == $past(acc.wdata) ##1 $stable(rx_base_o) || acc.wr)
    else $error("rx base not written");
  AST_LAST_START: assert property (pkt_info_i |=> last_start_r == $past(last_start_i)) // see RULE3
    else $error("packet start not captured");
  AST_IRQ_MASK: assert property (1'b1 |-> ##2 irq_o == $past(flags_r & ~mask_r, 1)) // see RULE4
    else $error("interrupt line does not follow flags and mask");
  AST_W1C: assert property (wr_hit(acc.wr, acc.addr, `MBR_ADR_IRQ_FLAGS) && // see RULE6
    evt_i == 8'h00 |=> flags_r == ($past(flags_r) & ~$past(acc.wdata)))
    else $error("flag clear mismatch");
  AST_ACT_FOUND: assert property (evt_i[`MBR_IRQ_ACT_FOUND] |=> // see RULE7
    flags_r[`MBR_IRQ_ACT_FOUND] ##1
    irq_o[`MBR_IRQ_ACT_FOUND] || $past(mask_r[`MBR_IRQ_ACT_FOUND]))
    else $error("activity flag not raised");
  AST_RX_LEN: assert property (!pkt_info_i |=> $stable(rx_len_r)) // see RULE8
    else $error("payload length changed without packet");
  AST_HDR_CNT: assert property (evt_i[`MBR_IRQ_HEADER_OK] && !cnt_clr |=> // see RULE9
    hdr_cnt_r == $past(hdr_cnt_r) + 16'h0001) else $error("header count not advanced");
  AST_PKT_CNT: assert property (!pkt_ok_i && !cnt_clr |=> $stable(pkt_cnt_r)) // see RULE10
    else $error("packet count moved without packet");
  AST_SLEEP_CLR: assert property (sleep_i |=> // see RULE11
    hdr_cnt_r == 16'h0000 && pkt_cnt_r == 16'h0000) else $error("counters not cleared in sleep");
  // The edge that releases reset still loads the reset value, so it is left out.
  AST_STATUS: assert property (!$past(rst_i) |=> // see RULE12
    stat_r == {$past(code_rate_i), $past(modem_flags_i)})
    else $error("status does not follow modem");
  AST_SNR_RO: assert property (wr_hit(acc.wr, acc.addr, `MBR_ADR_PKT_SNR) && // see RULE15
    !pkt_info_i |=> $stable(snr_r)) else $error("snr changed by a write");
  AST_BUF_PTR: assert property (wr_hit(acc.rd, acc.addr, `MBR_ADR_BUF_DATA) |=> // see RULE14
    buf_ptr_r == $past(buf_ptr_r) + 8'h01) else $error("buffer pointer did not advance");

  AST_BUF_PTR_WR: assert property (wr_hit(acc.wr, acc.addr, `MBR_ADR_BUF_PTR) |=> // see RULE14
    buf_ptr_r == $past(acc.wdata)) else $error("buffer pointer not written");
  AST_TX_HOLD: assert property (!wr_hit(acc.wr, acc.addr, `MBR_ADR_TX_BASE) |=> // see RULE1
    $stable(tx_base_o)) else $error("tx base moved without a write");
  AST_RX_HOLD: assert property (!wr_hit(acc.wr, acc.addr, `MBR_ADR_RX_BASE) |=> // see RULE2
    $stable(rx_base_o)) else $error("rx base moved without a write");
  AST_MASK_WR: assert property (wr_hit(acc.wr, acc.addr, `MBR_ADR_IRQ_MASK) |=> // see RULE4
    mask_r == $past(acc.wdata)) else $error("interrupt mask not written");
  AST_PKT_UP: assert property (pkt_ok_i && !cnt_clr |=> // see RULE10
    pkt_cnt_r == $past(pkt_cnt_r) + 16'h0001) else $error("packet count not advanced");
  AST_HDR_HOLD: assert property (!evt_i[`MBR_IRQ_HEADER_OK] && !cnt_clr |=> // see RULE9
    $stable(hdr_cnt_r)) else $error("header count moved without header");
  AST_RX_ENTRY_CLR: assert property (rx_entry_i |=> // see RULE11
    hdr_cnt_r == 16'h0000 && pkt_cnt_r == 16'h0000) else $error("counters not cleared on entry");
  AST_PKT_INFO: assert property (pkt_info_i |=> // see RULE8 see RULE13
    rx_len_r == $past(rx_len_i) && snr_r == $past(snr_i))
    else $error("packet results not captured");
  AST_LAST_HOLD: assert property (!pkt_info_i |=> $stable(last_start_r)) // see RULE3
    else $error("packet start changed without packet");
  AST_SNR_HOLD: assert property (!pkt_info_i |=> $stable(snr_r)) // see RULE13
    else $error("snr changed without packet");
  AST_HDR_RO: assert property (wr_hit(acc.wr, acc.addr, `MBR_ADR_HDR_CNT_LO) && // see RULE15
    !evt_i[`MBR_IRQ_HEADER_OK] && !cnt_clr |=> $stable(hdr_cnt_r))
    else $error("header count changed by a write");

  // Checked bit by bit, so an event wired to the wrong flag position fails at that position.
  for (genvar b = 0; b < 8; b++) begin : g_flag_chk
    AST_FLAG_SET: assert property (evt_i[b] |=> flags_r[b]) // see RULE5
      else $error("event did not set its flag");
    AST_FLAG_KEEP: assert property (!evt_i[b] && // see RULE15
      !(wr_hit(acc.wr, acc.addr, `MBR_ADR_IRQ_FLAGS) && acc.wdata[b]) |=> $stable(flags_r[b]))
      else $error("flag moved without event or clear");
    AST_LINE_MASK: assert property (mask_r[b] |=> !irq_o[b]) // see RULE4
      else $error("masked flag reached its line");
  end
endmodule
`default_nettype wire

// ---- logic/mbr_spi_slave.sv ----
// Serial register port: first byte is write flag and address, then data bytes.
`include "mbr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mbr_spi_slave (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial pins.
  input wire logic sck_i,
  input wire logic nss_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // Register access.
  mbr_acc_if.spi acc
);
  logic [2:0] sck_s_r;
  logic [2:0] nss_n_s_r;
  logic [1:0] mosi_s_r;
  mbr_pkg::mbr_spi_e state_r;
  logic [2:0] bit_cnt_r;
  logic [6:0] rx_sr_r;
  logic is_wr_r;
  mbr_pkg::mbr_addr_t addr_r;
  logic load_r;
  logic fresh_r;
  logic [7:0] tx_sr_r;
  logic rise;
  logic fall;
  logic active;
  logic byte_done;
  mbr_pkg::mbr_byte_t rx_byte;
  mbr_pkg::mbr_addr_t addr_adv;

  // Pins are foreign to clk_i; only the synchronised copies feed logic.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_s_r <= 3'h0;
      nss_n_s_r <= 3'h7;
      mosi_s_r <= 2'h0;
    end else begin
      sck_s_r <= {sck_s_r[1:0], sck_i};
      nss_n_s_r <= {nss_n_s_r[1:0], nss_n_i};
      mosi_s_r <= {mosi_s_r[0], mosi_i};
    end
  end

  assign rise = sck_s_r[1] & ~sck_s_r[2];
  assign fall = ~sck_s_r[1] & sck_s_r[2];
  assign active = ~nss_n_s_r[1];
  assign byte_done = active && rise && (bit_cnt_r == `MBR_SPI_LAST_BIT);
  assign rx_byte = {rx_sr_r, mosi_s_r[1]};
  // The buffer data address stays put in a burst; the buffer pointer walks instead.
  assign addr_adv = (addr_r == `MBR_ADR_BUF_DATA) ? addr_r : addr_r + 7'h01;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= mbr_pkg::SPI_IDLE;
      bit_cnt_r <= 3'h0;
      rx_sr_r <= 7'h00;
      is_wr_r <= 1'b0;
      addr_r <= 7'h00;
      acc.addr <= 7'h00;
      acc.wr <= 1'b0;
      acc.rd <= 1'b0;
      acc.wdata <= 8'h00;
    end else begin
      acc.wr <= 1'b0;
      acc.rd <= 1'b0;
      if (!active) begin
        state_r <= mbr_pkg::SPI_IDLE;
        bit_cnt_r <= 3'h0;
      end else begin
        if (rise) begin
          rx_sr_r <= rx_byte[6:0];
          bit_cnt_r <= bit_cnt_r + 3'h1;
        end
        case (state_r)
          mbr_pkg::SPI_IDLE: begin
            state_r <= mbr_pkg::SPI_ADDR;
          end
          mbr_pkg::SPI_ADDR: begin
            if (byte_done) begin
              state_r <= mbr_pkg::SPI_DATA;
              is_wr_r <= rx_byte[`MBR_SPI_WRITE_BIT];
              addr_r <= rx_byte[6:0];
              acc.addr <= rx_byte[6:0];
              acc.rd <= ~rx_byte[`MBR_SPI_WRITE_BIT];
            end
          end
          mbr_pkg::SPI_DATA: begin
            if (byte_done) begin
              addr_r <= addr_adv;
              if (is_wr_r) begin
                acc.addr <= addr_r;
                acc.wr <= 1'b1;
                acc.wdata <= rx_byte;
              end else begin
                acc.addr <= addr_adv;
                acc.rd <= 1'b1;
              end
            end
          end
          default: begin
            state_r <= mbr_pkg::SPI_IDLE;
          end
        endcase
      end
    end
  end

  // Read data is loaded before the falling edge that would present its first bit.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      load_r <= 1'b0;
      fresh_r <= 1'b0;
      tx_sr_r <= 8'h00;
      miso_oe_o <= 1'b0;
    end else begin
      load_r <= acc.rd;
      miso_oe_o <= active;
      if (!active) begin
        fresh_r <= 1'b0;
        tx_sr_r <= 8'h00;
      end else if (load_r) begin
        fresh_r <= 1'b1;
        tx_sr_r <= acc.rdata;
      end else if (fall) begin
        if (fresh_r) begin
          fresh_r <= 1'b0;
        end else begin
          tx_sr_r <= {tx_sr_r[6:0], 1'b0};
        end
      end
    end
  end

  assign miso_o = tx_sr_r[7];
endmodule
`default_nettype wire
